// ---- eeac_pkg.sv ----
/*
 * Constants shared by the EEPROM access control block: register selects,
 * field positions, reset values and timing counts.
 * Assumes a single 125 MHz CPU clock and a 1 MHz calibrated RC tick input.
 */
package eeac_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register selects on the CPU I/O port
    localparam logic [1:0]  EEAC_SEL_ADDR_LOW      = 2'h0;
    localparam logic [1:0]  EEAC_SEL_ADDR_HIGH     = 2'h1;
    localparam logic [1:0]  EEAC_SEL_DATA          = 2'h2;
    localparam logic [1:0]  EEAC_SEL_CONTROL       = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Array geometry
    localparam int          EEAC_ADDR_W            = 9;
    localparam int          EEAC_DEPTH             = 512;
    localparam int          EEAC_ADDR_HIGH_BIT     = 0;

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int          EEAC_READ_STROBE_BIT   = 0;
    localparam int          EEAC_WRITE_STROBE_BIT  = 1;
    localparam int          EEAC_MASTER_WE_BIT     = 2;
    localparam int          EEAC_READY_IE_BIT      = 3;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic        EEAC_READY_IE_RST      = 1'b0;
    localparam logic        EEAC_MASTER_WE_RST     = 1'b0;
    localparam logic [7:0]  EEAC_DATA_RST          = 8'h00;
    localparam logic [8:0]  EEAC_ADDR_RST          = 9'h000;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam real         EEAC_CLK_MHZ           = 125.0;
    localparam real         EEAC_RC_MHZ            = 1.0;
    localparam real         EEAC_WRITE_TIME_MS     = 8.5;
    localparam int          EEAC_RC_W              = 14;
    localparam logic [13:0] EEAC_WRITE_RC_CYCLES   = 14'd8448;
    localparam logic [2:0]  EEAC_MWE_TIMEOUT       = 3'h4;
    localparam logic [2:0]  EEAC_WRITE_STALL       = 3'h2;
    localparam logic [2:0]  EEAC_READ_STALL        = 3'h4;

endpackage : eeac_pkg

// ---- eeac_top.sv ----
/*
 * EEPROM access control: 512-byte data array behind address, data and
 * control registers on the CPU I/O port, guarded self-timed write, reads,
 * CPU stall and ready interrupt.
 * Assumes the CPU port, flash flag, status bit and RC tick are synchronous
 * to clk; por_b is the power-on reset that alone clears a write in flight.
 */
// Contract
// - Nine-bit address selects bytes 0 through 511 linearly.
// - Unused address high bits and control bits 7:4 read zero.
// - Address register has no meaningful reset; software loads it first.
// - Writes store data register byte; reads load addressed byte into it.
// - Ready interrupt stays high while enabled, global flag set, strobe clear.
// - Write starts only when strobe is set while master enable still set.
// - Master write enable clears itself four cycles after being set.
// - No write starts while flash programming is active.
// - Hardware clears the write strobe when the write time elapses.
// - Setting the write strobe stalls the CPU two cycles.
// - Read strobe reads immediately and stalls the CPU four cycles.
// - During a write, reads and address changes are refused.
// - Each write lasts 8448 ticks of the 1 MHz RC oscillator.
// - A write in flight completes through a CPU reset.
// - Write finishes in power-down; oscillator then keeps running.
`timescale 1ns/1ps

module eeac_top
    import eeac_pkg::*;
#(
    parameter logic [13:0] WRITE_RC_CYCLES = EEAC_WRITE_RC_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       por_b,
    input  wire logic [1:0] io_sel,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    input  wire logic       global_irq_flag,
    input  wire logic       flash_prog_enable_flag,
    input  wire logic       rc_tick,
    input  wire logic       power_down_req,
    output logic            ready_irq,
    output logic            cpu_stall,
    output logic            osc_keep_running
);

    ////////////////////////////////////////////////////////////////////////
    // State types

    typedef struct packed {
        logic [8:0] eeprom_byte_address;
        logic [7:0] eeprom_data;
        logic       ready_irq_enable;
        logic       master_write_enable;
        logic [2:0] mwe_timer;
        logic [2:0] stall_cnt;
        logic       stall;
        logic [7:0] rdata;
        logic       irq;
    } eeac_cpu_t;

    typedef struct packed {
        logic        busy;
        logic [13:0] rc_left;
        logic [8:0]  wr_addr;
        logic [7:0]  wr_data;
        logic        osc_keep;
    } eeac_eng_t;

    ////////////////////////////////////////////////////////////////////////
    // Reset synchronisers

    logic [1:0] rst_sync;
    logic [1:0] por_sync;
    logic       rst_n;
    logic       por_n;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            por_sync <= 2'b00;
        end else begin
            por_sync <= {por_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];
    assign por_n = por_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Storage array

    logic [7:0] mem [EEAC_DEPTH];

    eeac_cpu_t cpu;
    eeac_cpu_t next_cpu;
    eeac_eng_t eng;
    eeac_eng_t next_eng;

    logic       wr_ctrl;
    logic       start_write;
    logic       do_read;
    logic       write_done;
    logic [7:0] read_byte;

    assign read_byte = mem[cpu.eeprom_byte_address];

    ////////////////////////////////////////////////////////////////////////
    // CPU-facing registers

    always_comb begin
        next_cpu    = cpu;
        wr_ctrl     = io_wr && (io_sel == EEAC_SEL_CONTROL);
        start_write = 1'b0;
        do_read     = 1'b0;

        // Enable timeout counts down from the setting edge
        if (cpu.mwe_timer != 3'h0) begin
            next_cpu.mwe_timer = cpu.mwe_timer - 3'h1;
            if (cpu.mwe_timer == 3'h1) begin
                next_cpu.master_write_enable = 1'b0;
            end
        end

        if (cpu.stall_cnt != 3'h0) begin
            next_cpu.stall_cnt = cpu.stall_cnt - 3'h1;
        end

        if (io_wr && io_sel == EEAC_SEL_ADDR_LOW && !eng.busy) begin
            next_cpu.eeprom_byte_address[7:0] = io_wdata;
        end
        if (io_wr && io_sel == EEAC_SEL_ADDR_HIGH && !eng.busy) begin
            next_cpu.eeprom_byte_address[8] = io_wdata[EEAC_ADDR_HIGH_BIT];
        end
        if (io_wr && io_sel == EEAC_SEL_DATA) begin
            next_cpu.eeprom_data = io_wdata;
        end

        if (wr_ctrl) begin
            next_cpu.ready_irq_enable = io_wdata[EEAC_READY_IE_BIT];
            // Strobe judged against the enable held before this write
            if (io_wdata[EEAC_WRITE_STROBE_BIT] && cpu.master_write_enable
                && !eng.busy && !flash_prog_enable_flag) begin
                start_write = 1'b1;
                next_cpu.master_write_enable = 1'b0;
                next_cpu.mwe_timer = 3'h0;
                next_cpu.stall_cnt = EEAC_WRITE_STALL;
            end else if (io_wdata[EEAC_MASTER_WE_BIT]) begin
                next_cpu.master_write_enable = 1'b1;
                next_cpu.mwe_timer = EEAC_MWE_TIMEOUT;
            end
            do_read = io_wdata[EEAC_READ_STROBE_BIT] && !eng.busy && !start_write;
            if (do_read) begin
                next_cpu.eeprom_data = read_byte;
                next_cpu.stall_cnt = EEAC_READ_STALL;
            end
        end

        next_cpu.stall = (next_cpu.stall_cnt != 3'h0);

        // Register read-back, reserved bits as zero
        if (io_rd) begin
            unique case (io_sel)
                EEAC_SEL_ADDR_LOW:  next_cpu.rdata = cpu.eeprom_byte_address[7:0];
                EEAC_SEL_ADDR_HIGH: next_cpu.rdata = {7'h00, cpu.eeprom_byte_address[8]};
                EEAC_SEL_DATA:      next_cpu.rdata = cpu.eeprom_data;
                EEAC_SEL_CONTROL:   next_cpu.rdata = {4'h0, cpu.ready_irq_enable,
                                                      cpu.master_write_enable, eng.busy, 1'b0};
            endcase
        end

        next_cpu.irq = next_cpu.ready_irq_enable && global_irq_flag && !next_eng.busy;
    end

    // Address has no documented reset; a constant is used only to keep it defined
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu <= '{eeprom_byte_address: EEAC_ADDR_RST,
                     eeprom_data:         EEAC_DATA_RST,
                     ready_irq_enable:    EEAC_READY_IE_RST,
                     master_write_enable: EEAC_MASTER_WE_RST,
                     mwe_timer:           3'h0,
                     stall_cnt:           3'h0,
                     stall:               1'b0,
                     rdata:               8'h00,
                     irq:                 1'b0};
        end else begin
            cpu <= next_cpu;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Self-timed write engine, cleared only by power-on reset

    always_comb begin
        next_eng   = eng;
        write_done = 1'b0;

        if (start_write) begin
            next_eng.busy    = 1'b1;
            next_eng.rc_left = WRITE_RC_CYCLES;
            next_eng.wr_addr = cpu.eeprom_byte_address;
            next_eng.wr_data = cpu.eeprom_data;
        end else if (eng.busy && rc_tick) begin
            if (eng.rc_left <= 14'h0001) begin
                write_done    = 1'b1;
                next_eng.busy = 1'b0;
                next_eng.rc_left = 14'h0000;
            end else begin
                next_eng.rc_left = eng.rc_left - 14'h0001;
            end
        end

        // Oscillator held on once a write met power-down, until power-down ends
        if (!power_down_req) begin
            next_eng.osc_keep = 1'b0;
        end else if (eng.busy) begin
            next_eng.osc_keep = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            eng <= '{busy:     1'b0,
                     rc_left:  14'h0000,
                     wr_addr:  9'h000,
                     wr_data:  8'h00,
                     osc_keep: 1'b0};
        end else begin
            eng <= next_eng;
        end
    end

    always_ff @(posedge clk) begin
        if (write_done) begin
            mem[eng.wr_addr] <= eng.wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign io_rdata         = cpu.rdata;
    assign ready_irq        = cpu.irq;
    assign cpu_stall        = cpu.stall;
    assign osc_keep_running = eng.osc_keep;

endmodule : eeac_top

// ---- eeac_top_asserts.sv ----
/* Port checker for eeac_top: stall lengths, write guard, read-back.
   Bound to every eeac_top; sees its ports only. */
`timescale 1ns/1ps
module eeac_top_asserts
    import eeac_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [1:0] io_sel,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       global_irq_flag,
    input wire logic       flash_prog_enable_flag,
    input wire logic       ready_irq,
    input wire logic       cpu_stall
);
    logic ctl_wr;
    logic en_wr;
    assign ctl_wr = io_wr && io_sel == EEAC_SEL_CONTROL;
    assign en_wr = ctl_wr && io_wdata[2:1] == 2'h2;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    stall_len_a: assert property ($rose(cpu_stall) |-> cpu_stall[*2] ##1
        (!cpu_stall or cpu_stall[*2] ##1 !cpu_stall)) else $error("bad stall length");
    stall_cause_a: assert property ($rose(cpu_stall) |-> $past(ctl_wr)) else $error("stray stall");
    flash_block_a: assert property (ctl_wr && io_wdata[1:0] == 2'h2 && flash_prog_enable_flag
        |=> !$rose(cpu_stall)) else $error("write during flash");
    mwe_window_a: assert property (ctl_wr && io_wdata[1:0] == 2'h2 && !$past(en_wr) && !$past(en_wr, 2)
        && !$past(en_wr, 3) && !$past(en_wr, 4) |=> !$rose(cpu_stall)) else $error("write without enable");
    rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata)) else $error("read data moved");
    rsvd_high_a: assert property (io_rd && io_sel == EEAC_SEL_ADDR_HIGH |=> io_rdata[7:1] == 7'h00)
        else $error("address high spare set");
    rsvd_ctrl_a: assert property (io_rd && io_sel == EEAC_SEL_CONTROL |=> io_rdata[7:4] == 4'h0)
        else $error("control spare set");
    irq_gate_a: assert property (ready_irq |-> $past(global_irq_flag)) else $error("irq without flag");
    cover property ($rose(cpu_stall));
    cover property ($rose(ready_irq));
    cover property (en_wr ##2 ctl_wr);
endmodule : eeac_top_asserts

bind eeac_top eeac_top_asserts u_chk (.clk(clk), .rst_b(rst_b), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_flag(global_irq_flag),
    .flash_prog_enable_flag(flash_prog_enable_flag), .ready_irq(ready_irq), .cpu_stall(cpu_stall));

// ---- eeac_top_bench.sv ----
/* Bench for eeac_top: scenarios driven on the CPU port.
   Write time cut to 5 RC ticks, one tick per 8 clocks. */
`timescale 1ns/1ps
module eeac_top_bench;
    import eeac_pkg::*;
    logic       clk = 1'b0, rst_b = 1'b0, por_b = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
    logic       irq_flag = 1'b0, flash_flag = 1'b0, pd_req = 1'b0;
    logic       rc_tick, ready_irq, cpu_stall, osc_keep;
    logic [1:0] io_sel = 2'h0;
    logic [7:0] io_wdata = 8'h00, io_rdata, rv;
    logic [2:0] tcnt = 3'h0;
    int         n_mismatch = 0, n_compared = 0;
    assign rc_tick = tcnt == 3'h7;
    always #4 clk = ~clk;
    always @(posedge clk) tcnt <= #1 tcnt + 3'h1;
    eeac_top #(.WRITE_RC_CYCLES(14'd5)) dut (.clk(clk), .rst_b(rst_b), .por_b(por_b), .io_sel(io_sel),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_flag(irq_flag),
        .flash_prog_enable_flag(flash_flag), .rc_tick(rc_tick), .power_down_req(pd_req),
        .ready_irq(ready_irq), .cpu_stall(cpu_stall), .osc_keep_running(osc_keep));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One port access; read data is taken at the accepting edge
    task automatic io(input logic w, input logic [1:0] s, input logic [7:0] d);
        @(posedge clk) #1;
        {io_sel, io_wdata} = {s, d};
        {io_wr, io_rd} = {w, !w};
        @(posedge clk) #1;
        {io_wr, io_rd} = 2'h0;
        rv = io_rdata;
    endtask : io
    task automatic set_addr(input logic [8:0] a);
        io(1'b1, EEAC_SEL_ADDR_HIGH, {7'h00, a[8]});
        io(1'b1, EEAC_SEL_ADDR_LOW, a[7:0]);
    endtask : set_addr
    task automatic start_write(input logic [8:0] a, input logic [7:0] d, input logic [7:0] ie);
        set_addr(a);
        io(1'b1, EEAC_SEL_DATA, d);
        io(1'b1, EEAC_SEL_CONTROL, ie | 8'h04);
        io(1'b1, EEAC_SEL_CONTROL, ie | 8'h02);
        chk("write stall", 8'h01, {7'h00, cpu_stall});
        @(posedge clk) #1;
        chk("write stall", 8'h01, {7'h00, cpu_stall});
        @(posedge clk) #1;
        chk("write stall end", 8'h00, {7'h00, cpu_stall});
    endtask : start_write
    task automatic wait_idle;
        for (int i = 0; i < 100; i++) begin
            io(1'b0, EEAC_SEL_CONTROL, 8'h00);
            if (rv[1] === 1'b0) return;
        end
        chk("write done", 8'h00, rv & 8'h02);
    endtask : wait_idle
    task automatic read_mem(input logic [8:0] a, input logic [7:0] exp);
        set_addr(a);
        io(1'b1, EEAC_SEL_CONTROL, 8'h01);
        chk("read stall", 8'h01, {7'h00, cpu_stall});
        repeat (3) @(posedge clk);
        #1;
        chk("read stall", 8'h01, {7'h00, cpu_stall});
        @(posedge clk) #1;
        chk("read stall end", 8'h00, {7'h00, cpu_stall});
        io(1'b0, EEAC_SEL_DATA, 8'h00);
        chk("array byte", exp, rv);
    endtask : read_mem
    task automatic t_guard;
        io(1'b1, EEAC_SEL_CONTROL, 8'h02);
        io(1'b0, EEAC_SEL_CONTROL, 8'h00);
        chk("no enable", 8'h00, rv);
        io(1'b1, EEAC_SEL_CONTROL, 8'h04);
        repeat (5) @(posedge clk);
        io(1'b1, EEAC_SEL_CONTROL, 8'h02);
        io(1'b0, EEAC_SEL_CONTROL, 8'h00);
        chk("late strobe", 8'h00, rv);
        flash_flag = 1'b1;
        io(1'b1, EEAC_SEL_CONTROL, 8'h04);
        io(1'b1, EEAC_SEL_CONTROL, 8'h02);
        io(1'b0, EEAC_SEL_CONTROL, 8'h00);
        chk("flash busy", 8'h00, rv & 8'h02);
        flash_flag = 1'b0;
    endtask : t_guard
    task automatic t_write_read;
        start_write(9'h1ff, 8'ha5, 8'h00);
        io(1'b0, EEAC_SEL_ADDR_HIGH, 8'h00);
        chk("addr high", 8'h01, rv);
        wait_idle();
        start_write(9'h0ff, 8'h5a, 8'h00);
        io(1'b1, EEAC_SEL_ADDR_LOW, 8'h20);
        io(1'b1, EEAC_SEL_DATA, 8'h77);
        io(1'b1, EEAC_SEL_CONTROL, 8'h01);
        chk("no read stall", 8'h00, {7'h00, cpu_stall});
        io(1'b0, EEAC_SEL_DATA, 8'h00);
        chk("data in write", 8'h77, rv);
        io(1'b0, EEAC_SEL_ADDR_LOW, 8'h00);
        chk("addr in write", 8'hff, rv);
        wait_idle();
        read_mem(9'h1ff, 8'ha5);
        read_mem(9'h0ff, 8'h5a);
    endtask : t_write_read
    task automatic t_irq_reset;
        irq_flag = 1'b1;
        io(1'b1, EEAC_SEL_CONTROL, 8'h08);
        @(posedge clk) #1;
        chk("irq idle", 8'h01, {7'h00, ready_irq});
        start_write(9'h040, 8'h3c, 8'h08);
        chk("irq busy", 8'h00, {7'h00, ready_irq});
        pd_req = 1'b1;
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clk);
        wait_idle();
        chk("osc held", 8'h01, {7'h00, osc_keep});
        pd_req = 1'b0;
        irq_flag = 1'b0;
        @(posedge clk) #1;
        chk("osc free", 8'h00, {7'h00, osc_keep});
        read_mem(9'h040, 8'h3c);
    endtask : t_irq_reset
    task automatic summarize;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        #1 {rst_b, por_b} = 2'h3;
        repeat (3) @(posedge clk);
        t_guard();
        t_write_read();
        t_irq_reset();
        summarize();
    end
    initial begin
        #100000 n_mismatch++;
        summarize();
    end
endmodule : eeac_top_bench
